// [hw/remote_io_status_output_map.sv]
//Contract
// - Each channel's supply-terminal short sets its own supply short flag.
// - Supply short flags are reported in every channel mode.
// - Sensor drop flag is high while the sensor supply is at or below 18V.
// - Actuator drop flag is high while actuator supply is at or below 18V.
// - Deep drop flag is high while actuator supply is at or below 11V.
// - Deep drop flag never shows without the shallow actuator drop flag.
// - Comm started flag tracks protocol communication in protocol mode only.
// - Event pending flag sets when the protocol device raises an event.
// - Event pending clears only after the master read all pending events; the code also clears it when the channel leaves protocol mode.
// - Data valid flag shows valid process data, only in protocol mode.
// - Data valid flag stays low while the channel does not communicate.
// - Output bits pair per channel: even to comm terminal, odd to second.
// - Even output bit applies only in plain digital output mode.
// - Odd output bit applies in protocol and digital output modes only.
// - Mode command sets comm terminal to protocol; second stays plain.
// - Direction command makes a plain terminal an output when set.
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module remote_io_status_output_map (
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// Cyclic exchange with the network master.
	input wire logic cyc_exchange_in,
	input wire rio_map_pkg::ry_cmd_t ry_cmd_in,
	output rio_map_pkg::rx_flags_t rx_flags_out,
	// Detectors on pins, asynchronous to sys_clk_in.
	input wire logic [rio_map_pkg::NUM_CH-1:0] supply_short_in,
	input wire logic sensor_supply_low18_in,
	input wire logic actuator_supply_low18_in,
	input wire logic actuator_supply_low11_in,
	// Per-channel protocol logic, same clock.
	input wire logic [rio_map_pkg::NUM_CH-1:0] comm_active_in,
	input wire logic [rio_map_pkg::NUM_CH-1:0] event_raise_in,
	input wire logic [rio_map_pkg::NUM_CH-1:0] events_all_read_in,
	input wire logic [rio_map_pkg::NUM_CH-1:0] pd_valid_in,
	output logic [rio_map_pkg::NUM_CH-1:0] protocol_mode_out,
	// Terminal drivers.
	output rio_map_pkg::term_drive_t term_out,
	// Register port.
	input wire logic [rio_map_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [rio_map_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [rio_map_pkg::DATA_W-1:0] reg_rdata_out,
	output logic irq_out
);

	import rio_map_pkg::*;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [NUM_CH+2:0] pin_raw;
	logic [NUM_CH+2:0] pin_sync;
	logic [NUM_CH-1:0] short_s;
	logic sensor_low18_s;
	logic act_low18_s;
	logic act_low11_s;

	assign pin_raw = {actuator_supply_low11_in, actuator_supply_low18_in,
		sensor_supply_low18_in, supply_short_in};

	level_sync #(
		.WIDTH(NUM_CH + 3)
	) u_pin_sync (
		.sys_clk_in(sys_clk_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.async_in(pin_raw),
		.sync_out(pin_sync)
	);

	assign short_s = pin_sync[NUM_CH-1:0];
	assign sensor_low18_s = pin_sync[NUM_CH];
	assign act_low18_s = pin_sync[NUM_CH+1];
	assign act_low11_s = pin_sync[NUM_CH+2];

	// ------------------------------------------------------------------
	// Master command latch and event tracking
	// ------------------------------------------------------------------
	// Master bits are taken only on an exchange so that a half-updated
	// word never reaches the terminals.
	ry_cmd_t cmd_r;
	ry_cmd_t cmd_nxt;
	logic [NUM_CH-1:0] event_r;
	logic [NUM_CH-1:0] event_nxt;

	always_comb
	begin
		cmd_nxt = cmd_r;
		event_nxt = event_r;
		if (srst_in)
		begin
			cmd_nxt.out_bits = OUT_BITS_RST;
			cmd_nxt.dir_cmd = DIR_BITS_RST;
			cmd_nxt.protocol_mode_cmd = MODE_RST;
			event_nxt = '0;
		end
		else if (ce_in)
		begin
			if (cyc_exchange_in)
				cmd_nxt = ry_cmd_in;
			// A new event in the same cycle as the last read wins.
			event_nxt = (event_r & ~events_all_read_in) | event_raise_in;
			event_nxt = event_nxt & cmd_r.protocol_mode_cmd;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		cmd_r <= cmd_nxt;
		event_r <= event_nxt;
	end

	assign protocol_mode_out = cmd_r.protocol_mode_cmd;

	// ------------------------------------------------------------------
	// Live flag word and cyclic snapshot
	// ------------------------------------------------------------------
	rx_flags_t live;
	rx_flags_t flags_r;
	rx_flags_t flags_nxt;

	always_comb
	begin
		live.supply_short = short_s;
		live.sensor_supply_drop_flag = sensor_low18_s;
		// The deep drop forces the shallow one, even while the two
		// comparators disagree during a slow ramp.
		live.actuator_supply_drop_flag = act_low18_s | act_low11_s;
		live.actuator_supply_deep_drop_flag = act_low11_s;
		live.comm_started = comm_active_in & cmd_r.protocol_mode_cmd;
		live.event_pending = event_r;
		live.pd_valid = pd_valid_in & comm_active_in
			& cmd_r.protocol_mode_cmd;
	end

	always_comb
	begin
		flags_nxt = flags_r;
		if (srst_in)
			flags_nxt = '0;
		else if (ce_in && cyc_exchange_in)
			flags_nxt = live;
	end

	always_ff @(posedge sys_clk_in)
	begin
		flags_r <= flags_nxt;
	end

	assign rx_flags_out = flags_r;

	// ------------------------------------------------------------------
	// Terminal drivers
	// ------------------------------------------------------------------
	term_drive_t term_r;
	term_drive_t term_nxt;
	term_drive_t term_live;

	generate
		for (genvar ch = 0; ch < NUM_CH; ch++)
		begin : g_term
			logic proto;
			logic comm_dir;
			logic second_dir;
			assign proto = cmd_r.protocol_mode_cmd[ch];
			assign comm_dir = cmd_r.dir_cmd[2*ch];
			assign second_dir = cmd_r.dir_cmd[2*ch+1];

			// In protocol mode the comm terminal belongs to the protocol
			// transceiver, so this block lets go of it.
			assign term_live.comm_term_oe_n[ch] = proto | ~comm_dir;
			assign term_live.comm_term[ch] = ~proto & comm_dir
				& cmd_r.out_bits[2*ch];
			assign term_live.second_term_oe_n[ch] =
				~second_dir;
			assign term_live.second_term[ch] = second_dir
				& cmd_r.out_bits[2*ch+1];
		end
	endgenerate

	// A single process owns the whole next word, so every bit has one writer.
	always_comb
	begin
		term_nxt = term_r;
		if (srst_in)
		begin
			term_nxt.comm_term = '0;
			term_nxt.comm_term_oe_n = '1;
			term_nxt.second_term = '0;
			term_nxt.second_term_oe_n = '1;
		end
		else if (ce_in)
			term_nxt = term_live;
	end

	always_ff @(posedge sys_clk_in)
	begin
		term_r <= term_nxt;
	end

	assign term_out = term_r;

	// ------------------------------------------------------------------
	// Interrupt sources
	// ------------------------------------------------------------------
	logic [IRQ_W-1:0] irq_set;
	rx_flags_t prev_r;
	rx_flags_t prev_nxt;

	always_comb
	begin
		irq_set = '0;
		irq_set[IRQ_SHORT_POS] = |(live.supply_short & ~prev_r.supply_short);
		irq_set[IRQ_DROP_POS] =
			(live.sensor_supply_drop_flag & ~prev_r.sensor_supply_drop_flag)
			| (live.actuator_supply_drop_flag
			& ~prev_r.actuator_supply_drop_flag);
		irq_set[IRQ_EVENT_POS] = |(live.event_pending & ~prev_r.event_pending);
		irq_set[IRQ_COMM_POS] = |(live.comm_started ^ prev_r.comm_started);
	end

	always_comb
	begin
		prev_nxt = prev_r;
		if (srst_in)
			prev_nxt = '0;
		else if (ce_in)
			prev_nxt = live;
	end

	always_ff @(posedge sys_clk_in)
	begin
		prev_r <= prev_nxt;
	end

	// ------------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------------
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_stat_nxt;
	logic [IRQ_W-1:0] irq_mask_r;
	logic [IRQ_W-1:0] irq_mask_nxt;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic [DATA_W-1:0] rd_word;
	logic [IRQ_W-1:0] w1c;

	always_comb
	begin
		rd_word = '0;
		unique case (reg_addr_in)
			SUPPLY_FLAGS_OFS:
			begin
				rd_word[SHORT_POS +: NUM_CH] = flags_r.supply_short;
				rd_word[SENSOR_DROP_POS] = flags_r.sensor_supply_drop_flag;
				rd_word[ACT_DROP_POS] = flags_r.actuator_supply_drop_flag;
				rd_word[ACT_DEEP_DROP_POS] =
					flags_r.actuator_supply_deep_drop_flag;
			end
			CHAN_FLAGS_OFS:
			begin
				rd_word[COMM_POS +: NUM_CH] = flags_r.comm_started;
				rd_word[EVENT_POS +: NUM_CH] = flags_r.event_pending;
				rd_word[PDV_POS +: NUM_CH] = flags_r.pd_valid;
			end
			IRQ_STATUS_OFS: rd_word[IRQ_W-1:0] = irq_stat_r;
			IRQ_MASK_OFS: rd_word[IRQ_W-1:0] = irq_mask_r;
			OUT_CMD_OFS:
			begin
				rd_word[OUT_BITS_POS +: 2*NUM_CH] = cmd_r.out_bits;
				rd_word[DIR_BITS_POS +: 2*NUM_CH] = cmd_r.dir_cmd;
			end
			MODE_CMD_OFS: rd_word[NUM_CH-1:0] = cmd_r.protocol_mode_cmd;
			default: rd_word = '0;
		endcase
	end

	always_comb
	begin
		irq_stat_nxt = irq_stat_r;
		irq_mask_nxt = irq_mask_r;
		rdata_nxt = rdata_r;
		w1c = '0;
		if (srst_in)
		begin
			irq_stat_nxt = '0;
			irq_mask_nxt = IRQ_MASK_RST;
			rdata_nxt = RDATA_RST;
		end
		else if (ce_in)
		begin
			if (reg_wr_in && reg_addr_in == IRQ_STATUS_OFS)
				w1c = reg_wdata_in[IRQ_W-1:0];
			if (reg_wr_in && reg_addr_in == IRQ_MASK_OFS)
				irq_mask_nxt = reg_wdata_in[IRQ_W-1:0];
			// A source firing in the clearing cycle stays set.
			irq_stat_nxt = (irq_stat_r & ~w1c) | irq_set;
			// Read data stand for exactly one cycle after the strobe.
			rdata_nxt = reg_rd_in ? rd_word : '0;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		irq_stat_r <= irq_stat_nxt;
		irq_mask_r <= irq_mask_nxt;
		rdata_r <= rdata_nxt;
	end

	assign reg_rdata_out = rdata_r;
	assign irq_out = |(irq_stat_r & irq_mask_r);

endmodule : remote_io_status_output_map

`default_nettype wire

// [common/rio_map_pkg.sv]
package rio_map_pkg;

	localparam int NUM_CH = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// ------------------------------------------------------------------
	// Register offsets (byte addresses, one aligned word each)
	// ------------------------------------------------------------------
	localparam logic [7:0] SUPPLY_FLAGS_OFS = 8'h00;
	localparam logic [7:0] CHAN_FLAGS_OFS = 8'h04;
	localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
	localparam logic [7:0] OUT_CMD_OFS = 8'h10;
	localparam logic [7:0] MODE_CMD_OFS = 8'h14;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int SHORT_POS = 0;
	localparam int SENSOR_DROP_POS = 8;
	localparam int ACT_DROP_POS = 9;
	localparam int ACT_DEEP_DROP_POS = 10;
	localparam int COMM_POS = 0;
	localparam int EVENT_POS = 8;
	localparam int PDV_POS = 16;
	localparam int OUT_BITS_POS = 0;
	localparam int DIR_BITS_POS = 16;

	// Interrupt status and mask layout.
	localparam int IRQ_SHORT_POS = 0;
	localparam int IRQ_DROP_POS = 1;
	localparam int IRQ_EVENT_POS = 2;
	localparam int IRQ_COMM_POS = 3;
	localparam int IRQ_W = 4;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
	localparam logic [15:0] OUT_BITS_RST = 16'h0000;
	localparam logic [15:0] DIR_BITS_RST = 16'h0000;
	localparam logic [NUM_CH-1:0] MODE_RST = 8'h00;
	localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [NUM_CH-1:0] supply_short;
		logic sensor_supply_drop_flag;
		logic actuator_supply_drop_flag;
		logic actuator_supply_deep_drop_flag;
		logic [NUM_CH-1:0] comm_started;
		logic [NUM_CH-1:0] event_pending;
		logic [NUM_CH-1:0] pd_valid;
	} rx_flags_t;

	typedef struct packed {
		logic [2*NUM_CH-1:0] out_bits;
		logic [2*NUM_CH-1:0] dir_cmd;
		logic [NUM_CH-1:0] protocol_mode_cmd;
	} ry_cmd_t;

	typedef struct packed {
		logic [NUM_CH-1:0] comm_term;
		logic [NUM_CH-1:0] comm_term_oe_n;
		logic [NUM_CH-1:0] second_term;
		logic [NUM_CH-1:0] second_term_oe_n;
	} term_drive_t;

endpackage : rio_map_pkg

// [hw/level_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] sync_nxt;

	// The first stage feeds only the second stage.
	always_comb
	begin
		meta_nxt = meta_r;
		sync_nxt = sync_r;
		if (srst_in)
		begin
			meta_nxt = '0;
			sync_nxt = '0;
		end
		else if (ce_in)
		begin
			meta_nxt = async_in;
			sync_nxt = meta_r;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		meta_r <= meta_nxt;
		sync_r <= sync_nxt;
	end

	assign sync_out = sync_r;

endmodule : level_sync

`default_nettype wire

// [testbench/rio_proto_model.sv]
`timescale 1ns/1ps
`default_nettype none

module rio_proto_model (
	input wire logic [7:0] mode_in,
	input wire logic [7:0] link_in,
	input wire logic [7:0] stray_in,
	input wire logic [7:0] kick_in,
	input wire logic [7:0] drain_in,
	output logic [7:0] comm_out,
	output logic [7:0] raise_out,
	output logic [7:0] read_out,
	output logic [7:0] pdv_out
);
	// ----------------------------------------------------------------
	// Channel protocol side
	// ----------------------------------------------------------------
	// A stray channel talks without a mode command, so the block may not
	// trust the far side to stay quiet outside protocol mode.
	assign comm_out = link_in & (mode_in | stray_in);
	// On a stray channel, stale data on a dead link still claims to be valid.
	assign pdv_out = comm_out | stray_in;
	assign raise_out = kick_in & mode_in;
	// A drain pulse means the master fetched every queued event.
	assign read_out = drain_in;
endmodule : rio_proto_model

`default_nettype wire

// [testbench/rio_map_asserts.sv]
`timescale 1ns/1ps
`default_nettype none

module rio_map_asserts (
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic cyc_exchange_in,
	input wire rio_map_pkg::rx_flags_t rx_flags_out,
	input wire logic [7:0] supply_short_in,
	input wire logic sensor_supply_low18_in,
	input wire logic actuator_supply_low18_in,
	input wire logic actuator_supply_low11_in,
	input wire logic [7:0] protocol_mode_out,
	input wire rio_map_pkg::term_drive_t term_out,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out
);
	import rio_map_pkg::*;
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [10:0] sup_exp;
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (srst_in);
	// A deep drop alone must still lift the shallow flag.
	assign sup_exp = {supply_short_in, sensor_supply_low18_in,
		actuator_supply_low18_in | actuator_supply_low11_in,
		actuator_supply_low11_in};

	a_deep_needs_shallow: assert property (
		rx_flags_out.actuator_supply_deep_drop_flag
		|-> rx_flags_out.actuator_supply_drop_flag)
		else $error("deep drop flag shown alone");
	a_pdv_needs_comm: assert property (
		(rx_flags_out.pd_valid & ~rx_flags_out.comm_started) == 8'h00)
		else $error("data valid without communication");
	a_flags_hold: assert property (
		!(ce_in && cyc_exchange_in) |=> $stable(rx_flags_out))
		else $error("flags moved between exchanges");
	a_mode_gates_comm: assert property (
		ce_in && cyc_exchange_in |=> (rx_flags_out.comm_started
		& ~$past(protocol_mode_out)) == 8'h00)
		else $error("comm flag outside protocol mode");
	a_comm_term_off: assert property (
		$past(ce_in) |->
		(~term_out.comm_term_oe_n & $past(protocol_mode_out)) == 8'h00)
		else $error("comm terminal driven in protocol mode");
	a_term_quiet: assert property (
		((term_out.comm_term & term_out.comm_term_oe_n)
		| (term_out.second_term & term_out.second_term_oe_n)) == 8'h00)
		else $error("undriven terminal shows a value");
	a_rdata_one_cycle: assert property (
		ce_in && !reg_rd_in |=> reg_rdata_out == 32'h0000_0000)
		else $error("read data outside read cycle");
	a_pins_reach_flags: assert property (
		(ce_in && $stable(sup_exp))[*3] ##0 (ce_in && cyc_exchange_in)
		|=> rx_flags_out[34:24] == $past(sup_exp))
		else $error("supply flags differ from pins");

	c_event_seen: cover property (rx_flags_out.event_pending != 8'h00);
	c_deep_drop: cover property (rx_flags_out.actuator_supply_deep_drop_flag);
	c_comm_driven: cover property (term_out.comm_term_oe_n != 8'hff);
endmodule : rio_map_asserts

bind remote_io_status_output_map rio_map_asserts i_rio_map_asserts (
	.sys_clk_in(sys_clk_in), .srst_in(srst_in), .ce_in(ce_in),
	.cyc_exchange_in(cyc_exchange_in), .rx_flags_out(rx_flags_out),
	.supply_short_in(supply_short_in),
	.sensor_supply_low18_in(sensor_supply_low18_in),
	.actuator_supply_low18_in(actuator_supply_low18_in),
	.actuator_supply_low11_in(actuator_supply_low11_in),
	.protocol_mode_out(protocol_mode_out), .term_out(term_out),
	.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out)
);

`default_nettype wire

// [testbench/remote_io_status_output_map_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module remote_io_status_output_map_bench;
	import rio_map_pkg::*;

	logic sys_clk_in = 1'b0, srst_in = 1'b1, ce_in = 1'b1;
	logic cyc = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [7:0] addr = 8'h00, sup = 8'h00, link = 8'h00;
	logic [7:0] stray = 8'h00, kick = 8'h00, drain = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [2:0] drop = 3'h0;
	ry_cmd_t ry = '0;
	logic [7:0] comm, raise, allrd, pdv, mode, pm;
	rx_flags_t rx;
	term_drive_t term;
	logic [31:0] rdata, rv;
	logic [63:0] rnd;
	logic irq;
	int n_fail = 0;
	int compares = 0;
	int seed = 32'h7624;

	always #12.5 sys_clk_in = ~sys_clk_in;

	remote_io_status_output_map i_remote_io_status_output_map (
		.sys_clk_in(sys_clk_in), .srst_in(srst_in), .ce_in(ce_in),
		.cyc_exchange_in(cyc), .ry_cmd_in(ry), .rx_flags_out(rx),
		.supply_short_in(sup), .sensor_supply_low18_in(drop[2]),
		.actuator_supply_low18_in(drop[1]),
		.actuator_supply_low11_in(drop[0]), .comm_active_in(comm),
		.event_raise_in(raise), .events_all_read_in(allrd),
		.pd_valid_in(pdv), .protocol_mode_out(mode), .term_out(term),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdata), .irq_out(irq)
	);

	rio_proto_model i_rio_proto_model (
		.mode_in(mode), .link_in(link), .stray_in(stray), .kick_in(kick),
		.drain_in(drain), .comm_out(comm), .raise_out(raise),
		.read_out(allrd), .pdv_out(pdv)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		compares++;
		if (s !== e)
		begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic xchg();
		@(posedge sys_clk_in);
		cyc <= 1'b1;
		@(posedge sys_clk_in);
		cyc <= 1'b0;
		@(negedge sys_clk_in);
	endtask : xchg

	task automatic reg_op(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk_in);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= ~w;
		@(posedge sys_clk_in);
		wr <= 1'b0;
		rd <= 1'b0;
		@(negedge sys_clk_in);
		rv = rdata;
	endtask : reg_op

	task automatic poke(input logic [7:0] k, input logic [7:0] d);
		@(posedge sys_clk_in);
		kick <= k;
		drain <= d;
		@(posedge sys_clk_in);
		kick <= 8'h00;
		drain <= 8'h00;
	endtask : poke

	function automatic term_drive_t exp_term(input ry_cmd_t c);
		term_drive_t t;
		for (int n = 0; n < NUM_CH; n++)
		begin
			t.comm_term_oe_n[n] = ~c.dir_cmd[2*n] | c.protocol_mode_cmd[n];
			t.comm_term[n] = ~t.comm_term_oe_n[n] & c.out_bits[2*n];
			t.second_term_oe_n[n] = ~c.dir_cmd[2*n+1];
			t.second_term[n] = c.dir_cmd[2*n+1] & c.out_bits[2*n+1];
		end
		return t;
	endfunction : exp_term

	task automatic end_sim();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	initial
	begin
		repeat (5000) @(posedge sys_clk_in);
		n_fail++;
		end_sim();
	end

	initial
	begin
		repeat (16) @(posedge sys_clk_in);
		srst_in <= 1'b0;
		pm = 8'h00;
		@(negedge sys_clk_in);
		chk("rx", 32'h0, rx[31:0]);
		chk("term", exp_term('0), term);
		for (int i = 0; i < 48; i++)
		begin
			rnd = {$random(seed), $random(seed)};
			if (i == 0)
				rnd = '1;
			@(posedge sys_clk_in);
			ry <= rnd[39:0];
			sup <= rnd[47:40];
			drop <= rnd[50:48];
			link <= rnd[58:51];
			stray <= {rnd[63:59], rnd[2:0]};
			repeat (3) @(posedge sys_clk_in);
			xchg();
			chk("sup", {sup, drop[2], |drop[1:0], drop[0]}, rx[34:24]);
			chk("comm", link & pm, rx.comm_started);
			chk("pdv", link & pm, rx.pd_valid);
			chk("mode", ry.protocol_mode_cmd, mode);
			@(negedge sys_clk_in);
			chk("term", exp_term(ry), term);
			pm = ry.protocol_mode_cmd;
		end
		rv = {21'h0, rx[34:24]};
		// Flipped pins reach the live word first, but no snapshot is taken
		// while the enable is low, so the supply flags keep the old values.
		@(posedge sys_clk_in);
		sup <= ~sup;
		repeat (3) @(posedge sys_clk_in);
		ce_in <= 1'b0;
		xchg();
		chk("frozen", rv, rx[34:24]);
		@(posedge sys_clk_in);
		ce_in <= 1'b1;
		ry <= 40'h04;
		link <= 8'h04;
		stray <= 8'h00;
		xchg();
		xchg();
		reg_op(1'b1, IRQ_MASK_OFS, 32'h4);
		reg_op(1'b1, IRQ_STATUS_OFS, 32'hf);
		chk("irq", 1'b0, irq);
		poke(8'h04, 8'h00);
		xchg();
		chk("event", 8'h04, rx.event_pending);
		chk("irq", 1'b1, irq);
		xchg();
		chk("event", 8'h04, rx.event_pending);
		poke(8'h00, 8'h04);
		xchg();
		chk("event", 8'h00, rx.event_pending);
		reg_op(1'b1, IRQ_STATUS_OFS, 32'h4);
		chk("irq", 1'b0, irq);
		reg_op(1'b1, IRQ_MASK_OFS, 32'h0);
		poke(8'h04, 8'h00);
		xchg();
		chk("irq", 1'b0, irq);
		reg_op(1'b0, IRQ_STATUS_OFS, 32'h0);
		chk("status", 1'b1, rv[2]);
		reg_op(1'b0, CHAN_FLAGS_OFS, 32'h0);
		chk("chan", 32'h0004_0404, rv);
		reg_op(1'b1, MODE_CMD_OFS, 32'hff);
		reg_op(1'b0, MODE_CMD_OFS, 32'h0);
		chk("ro", 32'h4, rv);
		reg_op(1'b0, 8'h40, 32'h0);
		chk("unmapped", 32'h0, rv);
		@(posedge sys_clk_in);
		ry <= 40'h00;
		xchg();
		xchg();
		chk("event", 8'h00, rx.event_pending);
		end_sim();
	end
endmodule : remote_io_status_output_map_bench

`default_nettype wire
